/* File: pkg/bcfc_defs.vh */
// Constants for the bit count and float class unit
`ifndef BCFC_DEFS_VH
`define BCFC_DEFS_VH
`define BCFC_OP_PRIMARY_ZERO 6'h00
`define BCFC_OP_ALT_MAJOR    6'h1C
`define BCFC_OP_COPROC_TWO   6'h12
`define BCFC_OP_COPROC_ONE   6'h11
`define BCFC_FN_ONES_NEW     6'h11
`define BCFC_FN_ZEROS_NEW    6'h10
`define BCFC_FN_ONES_OLD     6'h21
`define BCFC_FN_ZEROS_OLD    6'h20
`define BCFC_FN_CLASS        6'h1B
`define BCFC_SHAMT_COUNT     5'h01
`define BCFC_SHAMT_OLD       5'h00
`define BCFC_SUB_CTRL_FROM   5'h02
`define BCFC_FMT_SINGLE      5'h10
`define BCFC_FMT_DOUBLE      5'h11
`define BCFC_MASK_SNAN       0
`define BCFC_MASK_QNAN       1
`define BCFC_MASK_NEG_INF    2
`define BCFC_MASK_NEG_NORM   3
`define BCFC_MASK_NEG_SUB    4
`define BCFC_MASK_NEG_ZERO   5
`define BCFC_MASK_POS_INF    6
`define BCFC_MASK_POS_NORM   7
`define BCFC_MASK_POS_SUB    8
`define BCFC_MASK_POS_ZERO   9
`define BCFC_RESET_RESULT    64'h0000000000000000
`define BCFC_RESET_WORD      32'h00000000
`define BCFC_RESET_ADDR      5'h00
`endif

/* File: logic/bcfc_lead_count.v */
// Leading-zero counter over a 32-bit word, result 0..32
`timescale 1ns/1ps
module bcfc_lead_count (
	input  wire [31:0] word,   // Word scanned from bit 31 down
	output reg  [5:0]  count   // Leading zeros, 32 when all zero
);
	integer i;
	reg     found;
	always @* begin
		count = 6'h20;
		found = 1'b0;
		for (i = 31; i >= 0; i = i - 1) begin
			if (!found && word[i]) begin
				count = 6'h1F - i[5:0];
				found = 1'b1;
			end
		end
	end
endmodule

/* File: logic/bcfc_unit.v */
// Bit count, float class and coprocessor-2 control read datapath
// What this block does
// - Count leading ones from bit 31; all ones gives 32.
// - Count leading zeros from bit 31; all zeros gives 32.
// - New encoding: opcode zero, second field 00000, bits 10..6 00001, functions 010001/010000.
// - Class sets bit 0 for signaling NaN, bit 1 for quiet NaN.
// - Negative: bit 2 infinity, 3 normal, 4 subnormal, 5 zero.
// - Positive: bit 6 infinity, 7 normal, 8 subnormal, 9 zero.
// - Class uses raw input; flush-subnormal setting has no effect.
// - Class mask zero-extended to 64 bits for both formats; upper input bits ignored for single.
// - Class never raises a value-dependent exception.
// - Class accepts only single and double; others reserved-instruction.
// - Control read copies selected 32-bit coprocessor-2 word into second field register.
// - Class and control read may trap; counts never trap.
`timescale 1ns/1ps
`include "bcfc_defs.vh"
module bcfc_unit (
	input  wire        clk,              // Processor clock
	input  wire        rst_b,            // Async reset, active low
	input  wire        issue,            // Instruction valid this cycle
	input  wire [31:0] instr,            // Instruction word
	input  wire [31:0] src_reg_value,    // General register named by src_reg_field
	input  wire [63:0] fp_source_value,  // Float register named by fp_source_field
	input  wire        cop_one_usable,   // Coprocessor 1 enabled
	input  wire        cop_two_usable,   // Coprocessor 2 enabled
	input  wire [31:0] coproc_two_opcode_ctrl_word,   // Control word returned by coprocessor 2
	output wire [15:0] coproc_two_opcode_ctrl_sel,    // Selector presented to coprocessor 2
	output wire        coproc_two_opcode_ctrl_rd,     // Control read strobe to coprocessor 2
	output reg         gpr_we,           // General register write
	output reg  [4:0]  gpr_waddr,        // General register destination
	output reg  [31:0] gpr_wdata,        // General register data
	output reg         fpr_we,           // Float register write
	output reg  [4:0]  fpr_waddr,        // Float register destination
	output reg  [63:0] fpr_wdata,        // Float register data
	output reg         exc_cop_unusable, // Coprocessor unusable exception
	output reg         exc_reserved,     // Reserved instruction exception
	output reg         claimed           // Instruction was one of ours
);
	wire [5:0] opcode           = instr[31:26];
	wire [4:0] src_reg_field    = instr[25:21];
	wire [4:0] second_reg_field = instr[20:16];
	wire [4:0] dest_field       = instr[15:11];
	wire [4:0] shamt            = instr[10:6];
	wire [5:0] funct            = instr[5:0];
	wire [4:0] fmt              = instr[25:21];
	wire [4:0] fp_source_field  = instr[15:11];
	wire [4:0] fp_dest_field    = instr[10:6];

	// Decode
	wire count_new = (opcode == `BCFC_OP_PRIMARY_ZERO) && (second_reg_field == 5'h00) &&
			(shamt == `BCFC_SHAMT_COUNT);
	wire ones_new = count_new && (funct == `BCFC_FN_ONES_NEW);
	wire zeros_new = count_new && (funct == `BCFC_FN_ZEROS_NEW);
	// Old form trusts software to repeat rd in the second field; rd is used
	wire count_old = (opcode == `BCFC_OP_ALT_MAJOR) && (shamt == `BCFC_SHAMT_OLD);
	wire ones_old = count_old && (funct == `BCFC_FN_ONES_OLD);
	wire zeros_old = count_old && (funct == `BCFC_FN_ZEROS_OLD);
	wire count_leading_ones_op  = ones_new || ones_old;
	wire count_leading_zeros_op = zeros_new || zeros_old;
	wire coproc_two_opcode_control_read = (opcode == `BCFC_OP_COPROC_TWO) &&
			(src_reg_field == `BCFC_SUB_CTRL_FROM);
	wire class_any = (opcode == `BCFC_OP_COPROC_ONE) && (second_reg_field == 5'h00) &&
			(funct == `BCFC_FN_CLASS);
	wire fmt_single = (fmt == `BCFC_FMT_SINGLE);
	wire fmt_double = (fmt == `BCFC_FMT_DOUBLE);
	// Other formats at this function are claimed and trap as reserved
	wire class_op = class_any && (fmt_single || fmt_double);

	// Counting: ones are counted as zeros of the inverted word
	wire [31:0] count_in = count_leading_ones_op ? ~src_reg_value : src_reg_value;
	wire [5:0]  lead_count;
	bcfc_lead_count u_count (
		.word  (count_in),
		.count (lead_count)
	);

	// Coprocessor-2 selector; value for a missing register is whatever it returns
	assign coproc_two_opcode_ctrl_sel = instr[15:0];
	assign coproc_two_opcode_ctrl_rd  = issue && coproc_two_opcode_control_read && cop_two_usable;

	// Class: raw bits only, no flush setting input exists
	// Single uses only the low 32 bits
	reg        sign;
	reg        exp_ones;
	reg        exp_zero;
	reg        frac_zero;
	reg        frac_top;
	reg [9:0]  mask;
	always @* begin
		if (fmt_double) begin
			sign      = fp_source_value[63];
			exp_ones  = &fp_source_value[62:52];
			exp_zero  = ~|fp_source_value[62:52];
			frac_zero = ~|fp_source_value[51:0];
			frac_top  = fp_source_value[51];
		end else begin
			sign      = fp_source_value[31];
			exp_ones  = &fp_source_value[30:23];
			exp_zero  = ~|fp_source_value[30:23];
			frac_zero = ~|fp_source_value[22:0];
			frac_top  = fp_source_value[22];
		end
		mask = 10'h000;
		// Priority chain keeps exactly one bit set
		if (exp_ones && !frac_zero) begin
			if (frac_top)
				mask[`BCFC_MASK_QNAN] = 1'b1;
			else
				mask[`BCFC_MASK_SNAN] = 1'b1;
		end else if (sign) begin
			if (exp_ones)
				mask[`BCFC_MASK_NEG_INF] = 1'b1;
			else if (!exp_zero)
				mask[`BCFC_MASK_NEG_NORM] = 1'b1;
			else if (!frac_zero)
				mask[`BCFC_MASK_NEG_SUB] = 1'b1;
			else
				mask[`BCFC_MASK_NEG_ZERO] = 1'b1;
		end else begin
			if (exp_ones)
				mask[`BCFC_MASK_POS_INF] = 1'b1;
			else if (!exp_zero)
				mask[`BCFC_MASK_POS_NORM] = 1'b1;
			else if (!frac_zero)
				mask[`BCFC_MASK_POS_SUB] = 1'b1;
			else
				mask[`BCFC_MASK_POS_ZERO] = 1'b1;
		end
	end

	// Zero-extended to 64 for both formats; upper word of single is zero
	wire [63:0] class_result = {54'h0, mask};

	// Next-state
	reg        next_gpr_we;
	reg [4:0]  next_gpr_waddr;
	reg [31:0] next_gpr_wdata;
	reg        next_fpr_we;
	reg        next_exc_cu;
	reg        next_exc_ri;
	reg        next_claimed;
	always @* begin
		next_gpr_we    = 1'b0;
		next_gpr_waddr = dest_field;
		next_gpr_wdata = 32'h00000000;
		next_fpr_we    = 1'b0;
		next_exc_cu    = 1'b0;
		next_exc_ri    = 1'b0;
		next_claimed   = 1'b0;
		if (issue) begin
			if (count_leading_ones_op || count_leading_zeros_op) begin
				// Counts never trap
				next_claimed   = 1'b1;
				next_gpr_we    = 1'b1;
				next_gpr_wdata = {26'h0, lead_count};
			end else if (coproc_two_opcode_control_read) begin
				next_claimed = 1'b1;
				if (!cop_two_usable) begin
					next_exc_cu = 1'b1;
				end else begin
					next_gpr_we    = 1'b1;
					next_gpr_waddr = second_reg_field;
					next_gpr_wdata = coproc_two_opcode_ctrl_word;
				end
			end else if (class_any) begin
				next_claimed = 1'b1;
				if (!cop_one_usable)
					next_exc_cu = 1'b1;
				else if (!class_op)
					next_exc_ri = 1'b1;
				else
					next_fpr_we = 1'b1;  // No value-based trap
			end
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gpr_we           <= 1'b0;
			gpr_waddr        <= `BCFC_RESET_ADDR;
			gpr_wdata        <= `BCFC_RESET_WORD;
			fpr_we           <= 1'b0;
			fpr_waddr        <= `BCFC_RESET_ADDR;
			fpr_wdata        <= `BCFC_RESET_RESULT;
			exc_cop_unusable <= 1'b0;
			exc_reserved     <= 1'b0;
			claimed          <= 1'b0;
		end else begin
			gpr_we           <= next_gpr_we;
			gpr_waddr        <= next_gpr_waddr;
			gpr_wdata        <= next_gpr_wdata;
			fpr_we           <= next_fpr_we;
			fpr_waddr        <= fp_dest_field;
			fpr_wdata        <= class_result;
			exc_cop_unusable <= next_exc_cu;
			exc_reserved     <= next_exc_ri;
			claimed          <= next_claimed;
		end
	end
endmodule

/* File: verif/bcfc_coproc_two_opcode_model.sv */
// Coprocessor two control register model
`timescale 1ns/1ps
module bcfc_coproc_two_opcode_model (
	input  wire [15:0] sel,  // Selector
	input  wire        rd,   // Read strobe
	output wire [31:0] word  // Control word
);
	// Unselected: inverted pattern so a stale sample shows
	assign word = rd ? {~sel, sel} ^ 32'h5A5A5A5A : {sel, ~sel};
endmodule

/* File: verif/bcfc_unit_asserts.sv */
// Port assertions for the bit count and float class unit
`timescale 1ns/1ps
module bcfc_unit_asserts (
	input wire        clk,              // Clock
	input wire        rst_b,            // Reset
	input wire        issue,            // Valid
	input wire [31:0] instr,            // Instr
	input wire [31:0] src_reg_value,    // Source
	input wire        cop_one_usable,   // Cop1 on
	input wire        cop_two_usable,   // Coproc_two_opcode on
	input wire [31:0] coproc_two_opcode_ctrl_word,   // Coproc_two_opcode word
	input wire [15:0] coproc_two_opcode_ctrl_sel,    // Selector
	input wire        coproc_two_opcode_ctrl_rd,     // Read strobe
	input wire        gpr_we,           // Write
	input wire [4:0]  gpr_waddr,        // Dest
	input wire [31:0] gpr_wdata,        // Data
	input wire        fpr_we,           // Float write
	input wire [63:0] fpr_wdata,        // Float data
	input wire        exc_cop_unusable, // Unusable
	input wire        exc_reserved,     // Reserved
	input wire        claimed           // Claimed
);
	wire cnt = issue && instr[31:26] == 6'h00 && instr[20:16] == 5'h00
		&& instr[10:6] == 5'h01 && instr[5:1] == 5'h08;
	wire cls = issue && instr[31:26] == 6'h11 && instr[20:16] == 5'h00
		&& instr[5:0] == 6'h1B && cop_one_usable;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_count; cnt ##1 gpr_we; endsequence
	sequence s_class_bad; cls && instr[25:22] != 4'h8; endsequence
	a_count_dest: assert property (cnt |=> gpr_we && claimed && gpr_waddr == $past(instr[15:11]))
		else $error("count write missing");
	a_zeros_full: assert property (cnt && !instr[0] && src_reg_value == 0 |=> gpr_wdata == 32'h20)
		else $error("zero word count wrong");
	a_ones_full: assert property (cnt && instr[0] && &src_reg_value |=> gpr_wdata == 32'h20)
		else $error("ones word count wrong");
	a_count_no_trap: assert property (s_count |-> !exc_reserved && !exc_cop_unusable)
		else $error("count raised exception");
	a_ctrl_sel_copy: assert property (coproc_two_opcode_ctrl_sel == instr[15:0])
		else $error("selector mismatch");
	a_ctrl_rd_gate: assert property (coproc_two_opcode_ctrl_rd |-> issue && cop_two_usable && instr[31:21] == 11'h242)
		else $error("read strobe bad");
	a_ctrl_copy: assert property (coproc_two_opcode_ctrl_rd |=> gpr_we && gpr_wdata == $past(coproc_two_opcode_ctrl_word))
		else $error("control word not copied");
	a_class_one_hot: assert property (fpr_we |-> $onehot(fpr_wdata[9:0]) && fpr_wdata[31:10] == 0)
		else $error("class mask not one hot");
	a_class_bad_fmt: assert property (s_class_bad |=> exc_reserved && !fpr_we)
		else $error("bad format not refused");
	a_class_no_trap: assert property (cls && instr[25:22] == 4'h8 |=> fpr_we && !exc_reserved)
		else $error("class trapped");
endmodule
bind bcfc_unit bcfc_unit_asserts u_asserts (
	.clk              (clk),
	.rst_b            (rst_b),
	.issue            (issue),
	.instr            (instr),
	.src_reg_value    (src_reg_value),
	.cop_one_usable   (cop_one_usable),
	.cop_two_usable   (cop_two_usable),
	.coproc_two_opcode_ctrl_word   (coproc_two_opcode_ctrl_word),
	.coproc_two_opcode_ctrl_sel    (coproc_two_opcode_ctrl_sel),
	.coproc_two_opcode_ctrl_rd     (coproc_two_opcode_ctrl_rd),
	.gpr_we           (gpr_we),
	.gpr_waddr        (gpr_waddr),
	.gpr_wdata        (gpr_wdata),
	.fpr_we           (fpr_we),
	.fpr_wdata        (fpr_wdata),
	.exc_cop_unusable (exc_cop_unusable),
	.exc_reserved     (exc_reserved),
	.claimed          (claimed)
);

/* File: verif/bcfc_unit_tb_top.sv */
// Self-checking bench for the bit count and float class unit
`timescale 1ns/1ps
module bcfc_unit_tb_top;
	reg         clk, rst_b, issue, cop_one_usable, cop_two_usable;
	reg  [31:0] instr, src_reg_value, w, r;
	reg  [63:0] fp_source_value, v, em, fm;
	reg  [4:0]  d;
	wire [31:0] coproc_two_opcode_ctrl_word, gpr_wdata;
	wire [15:0] coproc_two_opcode_ctrl_sel;
	wire [4:0]  gpr_waddr, fpr_waddr;
	wire [63:0] fpr_wdata;
	wire        coproc_two_opcode_ctrl_rd, gpr_we, fpr_we, exc_cop_unusable, exc_reserved, claimed;
	integer     fail_count = 0, tests_run = 0, cyc = 0, k, j;
	always #2.5 clk = ~clk;
	bcfc_unit dut (
		.clk              (clk),
		.rst_b            (rst_b),
		.issue            (issue),
		.instr            (instr),
		.src_reg_value    (src_reg_value),
		.fp_source_value  (fp_source_value),
		.cop_one_usable   (cop_one_usable),
		.cop_two_usable   (cop_two_usable),
		.coproc_two_opcode_ctrl_word   (coproc_two_opcode_ctrl_word),
		.coproc_two_opcode_ctrl_sel    (coproc_two_opcode_ctrl_sel),
		.coproc_two_opcode_ctrl_rd     (coproc_two_opcode_ctrl_rd),
		.gpr_we           (gpr_we),
		.gpr_waddr        (gpr_waddr),
		.gpr_wdata        (gpr_wdata),
		.fpr_we           (fpr_we),
		.fpr_waddr        (fpr_waddr),
		.fpr_wdata        (fpr_wdata),
		.exc_cop_unusable (exc_cop_unusable),
		.exc_reserved     (exc_reserved),
		.claimed          (claimed)
	);
	bcfc_coproc_two_opcode_model coproc_two_opcode (.sel(coproc_two_opcode_ctrl_sel), .rd(coproc_two_opcode_ctrl_rd), .word(coproc_two_opcode_ctrl_word));
	function [5:0] lead(input [31:0] x, input b);
		integer i;
		begin
			lead = 6'h20;
			for (i = 0; i < 32; i = i + 1)
				if (x[i] != b) lead = 6'h1F - i[5:0];
		end
	endfunction
	function [9:0] fclass(input [63:0] x, input dbl);
		reg s, emax, ezero, fz, q;
		begin
			s = dbl ? x[63] : x[31];
			emax = dbl ? &x[62:52] : &x[30:23];
			ezero = dbl ? ~|x[62:52] : ~|x[30:23];
			fz = dbl ? ~|x[51:0] : ~|x[22:0];
			q = dbl ? x[51] : x[22];
			fclass = 10'h000;
			if (emax) fclass[fz ? (s ? 2 : 6) : (q ? 1 : 0)] = 1'b1;
			else fclass[ezero ? (fz ? (s ? 5 : 9) : (s ? 4 : 8)) : (s ? 3 : 7)] = 1'b1;
		end
	endfunction
	task chk(input [63:0] got, input [63:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// Flags: claimed, unusable, reserved, gpr write, fpr write
	task op(input [31:0] i, input [31:0] s, input [63:0] f, input [4:0] ef, input [63:0] ed);
		begin
			@(negedge clk);
			instr = i;
			src_reg_value = s;
			fp_source_value = f;
			issue = 1'b1;
			@(posedge clk);
			#1;
			chk({claimed, exc_cop_unusable, exc_reserved, gpr_we, fpr_we}, ef);
			if (ef[1]) chk({gpr_waddr, gpr_wdata}, ed);
			if (ef[0]) chk(i[21] ? fpr_wdata : {32'h0, fpr_wdata[31:0]}, ed);
			if (ef[0]) chk(fpr_waddr, i[10:6]);
		end
	endtask
	task finish_test;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, fail_count);
			if (fail_count == 0 && tests_run > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			fail_count = fail_count + 1;
			finish_test;
		end
	end
	initial begin
		{clk, rst_b, issue, instr, src_reg_value, fp_source_value} = 0;
		{cop_one_usable, cop_two_usable} = 2'b11;
		w = $urandom(73);
		repeat (12) @(posedge clk);
		@(negedge clk) rst_b = 1'b1;
		for (k = 0; k < 60; k = k + 1) begin
			w = (k < 4) ? (k[1] ? 32'h7FFFFFFF : 32'h0) : $urandom >> ($urandom % 32);
			if (k[0]) w = ~w;
			d = $urandom;
			r = $urandom;
			for (j = 0; j < 4; j = j + 1)
				op(j[1] ? {6'h1C, r[4:0], d, d, 5'h00, 5'h10, j[0]} : {6'h00, r[4:0], 5'h00, d, 5'h01, 5'h08, j[0]}, w, 0, 5'h12, {d, 26'h0, lead(w, j[0])});
		end
		$display("count test done");
		for (k = 0; k < 80; k = k + 1) begin
			v = {$urandom, $urandom};
			em = k[0] ? 64'h7FF0000000000000 : 64'h7F800000;
			fm = k[0] ? 64'h000FFFFFFFFFFFFF : 64'h007FFFFF;
			j = $urandom % 4;
			v = (j == 0) ? v & ~em : (j == 1) ? v | em : v;
			if ($urandom % 3 == 0) v = v & ~fm;
			d = $urandom;
			op({6'h11, 4'h8, k[0], 5'h00, 5'h03, d, 6'h1B}, 0, v, 5'h11, {54'h0, fclass(v, k[0])});
		end
		op({6'h11, 5'h14, 15'h0, 6'h1B}, 0, 0, 5'h14, 0);
		@(negedge clk) cop_one_usable = 1'b0;
		op({6'h11, 5'h10, 15'h0, 6'h1B}, 0, 0, 5'h18, 0);
		@(negedge clk) cop_one_usable = 1'b1;
		$display("class test done");
		for (k = 0; k < 20; k = k + 1) begin
			r = $urandom;
			d = $urandom;
			@(negedge clk) cop_two_usable = (k != 0);
			op({6'h12, 5'h02, d, r[15:0]}, 0, 0, k ? 5'h12 : 5'h18, {d, {~r[15:0], r[15:0]} ^ 32'h5A5A5A5A});
		end
		op(32'hFC000000, 0, 0, 5'h00, 0);
		$display("control read test done");
		finish_test;
	end
endmodule
